// [common/rsp_pkg.sv]
// Constants shared by the reset, unit-loss and panel-stop policy logic
package rsp_pkg;

  // Policy setting encoding and legal ranges
  localparam int          POLICY_W      = 5;
  localparam logic [4:0]  POLICY_INIT   = 5'h0E;
  localparam logic [4:0]  POLICY_MAX_LO = 5'h03;
  localparam logic [4:0]  POLICY_MIN_HI = 5'h0E;
  localparam logic [4:0]  POLICY_MAX_HI = 5'h11;
  // Field positions of the folded setting (value minus range base)
  localparam int          POL_FAULT_ONLY_BIT = 0;
  localparam int          POL_TRIP_BIT       = 1;

  // Operating modes
  localparam logic [1:0]  MODE_OPER = 2'h0;
  localparam logic [1:0]  MODE_EXT  = 2'h1;
  localparam logic [1:0]  MODE_NET  = 2'h2;

  // Fault codes; values are arbitrary
  localparam logic [7:0]  FAULT_NONE      = 8'h00;
  localparam logic [7:0]  FAULT_UNIT_LOSS = 8'h5A;

  // Unit-loss interval
  localparam longint      CLK_HZ       = 20000000;
  localparam longint      LOSS_TIME_MS = 1000;
  localparam int unsigned LOSS_CYC_DEF = int'((CLK_HZ * LOSS_TIME_MS + 999) / 1000);

  // Panel-stop states
  typedef enum logic [1:0] {
    PS_IDLE = 2'b01,
    PS_HELD = 2'b10
  } rsp_ps_e;

endpackage : rsp_pkg

// [core/rsp_loss_timer.sv]
// Disconnection interval counter for the detachable operator unit
`timescale 1ns/100ps
`default_nettype none

module rsp_loss_timer #(
  parameter int unsigned LIMIT = 20000000
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic present,
  output logic      expired
);

  localparam int CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] LIM_C = CNT_W'(LIMIT);

  logic [CNT_W-1:0] cnt_q;

  if (LIMIT < 2) begin : g_chk
    $error("rsp_loss_timer: LIMIT must be at least 2");
  end

  // Restart on presence, held clear while disabled, saturate at the limit
  always_ff @(posedge core_clk) begin
    if (sys_rst || !enable || present) begin
      cnt_q <= '0;
    end else if (cnt_q != LIM_C) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Fires once the count reaches the limit, i.e. after LIMIT absent cycles
  assign expired = enable && !present && (cnt_q == LIM_C);

endmodule : rsp_loss_timer

`default_nettype wire

// [core/rsp_policy_ctrl.sv]
// Reset acceptance, operator-unit loss and panel-stop policy controller
`timescale 1ns/100ps
`default_nettype none

module rsp_policy_ctrl
  import rsp_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = LOSS_CYC_DEF
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                policy_wr,
  input  wire logic [POLICY_W-1:0] policy_wdata,
  output logic      [POLICY_W-1:0] policy_q,
  output logic                     policy_bad_q,
  input  wire logic                ext_reset_in,
  input  wire logic                comm_reset_req,
  input  wire logic                unit_reset_key,
  input  wire logic                fault_in,
  input  wire logic [7:0]          fault_in_code,
  input  wire logic                unit_present,
  input  wire logic                rs485_via_unit,
  input  wire logic                cmd_src_unit,
  input  wire logic                jog_from_unit,
  input  wire logic [1:0]          op_mode,
  input  wire logic                stop_key_panel,
  input  wire logic                stop_key_unit,
  input  wire logic                mode_key_panel,
  input  wire logic                mode_key_unit,
  input  wire logic                start_fwd,
  input  wire logic                start_rev,
  input  wire logic                motor_stopped,
  input  wire logic                stop_method_coast,
  output logic                     tripped_q,
  output logic                     fault_out,
  output logic      [7:0]          fault_code_q,
  output logic                     reset_exec_q,
  output logic                     drive_off_q,
  output logic                     accum_clr_q,
  output logic                     decel_stop_q,
  output logic                     coast_sel_q,
  output logic                     panel_stop_q,
  output logic                     ps_from_unit_q,
  output logic                     restart_ok
);

  if (LOSS_CYCLES < 2) begin : g_chk
    $error("rsp_policy_ctrl: LOSS_CYCLES must be at least 2");
  end

  rsp_ps_e ps_st_q;
  rsp_ps_e ps_st_d;

  logic [POLICY_W-1:0] pol_idx;
  logic                fault_only;
  logic                trip_sel;
  logic                ps_valid;
  logic                wr_ok;
  logic                ext_d1_q;
  logic                ext_rise;
  logic                reset_req;
  logic                reset_acc;
  logic                unit_seen_q;
  logic                unit_prev_q;
  logic                unit_drop;
  logic                loss_en;
  logic                loss_expired;
  logic                jog_stop;
  logic                src_panel;
  logic                src_unit;
  logic                in_oper;
  logic                key_any;
  logic                key_own;
  logic                ps_enter;
  logic                plain_stop;
  logic                starts_off;
  logic                ps_clear;

  // Setting decode: both ranges fold onto the same two feature bits
  always_comb begin
    if (policy_q >= POLICY_MIN_HI) begin
      pol_idx = policy_q - POLICY_MIN_HI;
    end else begin
      pol_idx = policy_q;
    end
  end

  assign fault_only = pol_idx[POL_FAULT_ONLY_BIT];
  assign trip_sel   = pol_idx[POL_TRIP_BIT];
  assign ps_valid   = policy_q >= POLICY_MIN_HI;

  assign wr_ok = (policy_wdata <= POLICY_MAX_LO) ||
                 ((policy_wdata >= POLICY_MIN_HI) && (policy_wdata <= POLICY_MAX_HI));

  // Only power-up restores the initial setting; no run or clear lock here
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      policy_q <= POLICY_INIT;
    end else if (policy_wr && wr_ok) begin
      policy_q <= policy_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      policy_bad_q <= 1'b0;
    end else begin
      policy_bad_q <= policy_wr && !wr_ok;
    end
  end

  // Reset input acts on its rising edge so a held level resets once
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_d1_q <= 1'b0;
    end else begin
      ext_d1_q <= ext_reset_in;
    end
  end

  assign ext_rise  = ext_reset_in && !ext_d1_q;
  assign reset_req = ext_rise || comm_reset_req;

  assign reset_acc = (reset_req && (!fault_only || tripped_q)) ||
                     (unit_reset_key && tripped_q);

  // One-cycle execution pulses for the output stage and accumulators
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reset_exec_q <= 1'b0;
      drive_off_q  <= 1'b0;
      accum_clr_q  <= 1'b0;
    end else begin
      reset_exec_q <= reset_acc;
      drive_off_q  <= reset_acc;
      accum_clr_q  <= reset_acc;
    end
  end

  // Unit presence history
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      unit_seen_q <= 1'b0;
      unit_prev_q <= 1'b0;
    end else begin
      unit_prev_q <= unit_present;
      if (unit_present) begin
        unit_seen_q <= 1'b1;
      end
    end
  end

  assign unit_drop = unit_prev_q && !unit_present;

  assign loss_en = trip_sel && !rs485_via_unit && unit_seen_q;

  rsp_loss_timer #(
    .LIMIT (LOSS_CYCLES)
  ) u_loss_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (loss_en),
    .present  (unit_present),
    .expired  (loss_expired)
  );

  // A new trip cause wins over a reset arriving in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tripped_q    <= 1'b0;
      fault_code_q <= FAULT_NONE;
    end else if (loss_expired) begin
      tripped_q    <= 1'b1;
      fault_code_q <= FAULT_UNIT_LOSS;
    end else if (fault_in) begin
      tripped_q    <= 1'b1;
      fault_code_q <= fault_in_code;
    end else if (reset_acc) begin
      tripped_q    <= 1'b0;
      fault_code_q <= FAULT_NONE;
    end
  end

  // Panel stop never drives this; only real trips do
  assign fault_out = tripped_q;

  assign jog_stop = unit_drop && jog_from_unit && !trip_sel;

  // Command source: RS-485 on the unit connector owns it over both keypads
  assign src_panel = !rs485_via_unit && !cmd_src_unit;
  assign src_unit  = !rs485_via_unit && cmd_src_unit;
  assign in_oper   = op_mode == MODE_OPER;
  assign key_any   = stop_key_panel || stop_key_unit;
  assign key_own   = (stop_key_panel && src_panel) || (stop_key_unit && src_unit);

  assign ps_enter = ps_valid && key_any && !(in_oper && key_own) &&
                    (ps_st_q == PS_IDLE);
  assign plain_stop = key_any && in_oper && (!ps_valid || key_own);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      decel_stop_q <= 1'b0;
    end else begin
      decel_stop_q <= ps_enter || plain_stop || jog_stop;
    end
  end

  // Clear waits for standstill and released starts, from the issuing unit
  assign starts_off = !start_fwd && !start_rev;
  assign ps_clear = motor_stopped && starts_off &&
                    (ps_from_unit_q ? mode_key_unit : mode_key_panel);

  always_comb begin
    ps_st_d = ps_st_q;
    case (ps_st_q)
      PS_IDLE: begin
        if (ps_enter) begin
          ps_st_d = PS_HELD;
        end
      end
      PS_HELD: begin
        if (ext_rise || ps_clear || !ps_valid) begin
          ps_st_d = PS_IDLE;
        end
      end
      default: ps_st_d = PS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ps_st_q <= PS_IDLE;
    end else begin
      ps_st_q <= ps_st_d;
    end
  end

  // Remember which keypad issued the stop; panel wins a tie
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ps_from_unit_q <= 1'b0;
    end else if (ps_enter) begin
      ps_from_unit_q <= !stop_key_panel;
    end
  end

  // A coast stop method is overridden while a panel stop is pending
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      coast_sel_q <= 1'b0;
    end else begin
      coast_sel_q <= stop_method_coast && (ps_st_d == PS_IDLE);
    end
  end

  assign panel_stop_q = ps_st_q == PS_HELD;
  assign restart_ok   = (ps_st_q == PS_IDLE) && !tripped_q;

  policy_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (policy_q <= POLICY_MAX_LO) || (policy_q >= POLICY_MIN_HI && policy_q <= POLICY_MAX_HI))
    else $error("policy setting outside legal range");

  policy_init_a: assert property (@(posedge core_clk)
    $past(sys_rst) && !sys_rst |-> policy_q == POLICY_INIT)
    else $error("policy setting not initial after reset");

  policy_wr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    policy_wr && wr_ok |=> policy_q == $past(policy_wdata))
    else $error("legal policy write not taken");

  reset_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reset_req && fault_only && !tripped_q && !unit_reset_key |=> !reset_exec_q)
    else $error("reset accepted while not tripped");

  reset_accept_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reset_req && !fault_only |=> reset_exec_q && drive_off_q && accum_clr_q)
    else $error("reset not executed");

  reset_effect_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reset_exec_q |-> drive_off_q && accum_clr_q)
    else $error("reset pulse without output cut or clear");

  accum_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    accum_clr_q |-> $past(reset_acc))
    else $error("accumulator clear without reset");

  key_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    unit_reset_key && !tripped_q && !reset_req |=> !reset_exec_q)
    else $error("unit reset key honoured while not tripped");

  key_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    unit_reset_key && tripped_q |=> reset_exec_q)
    else $error("unit reset key ignored while tripped");

  loss_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    loss_expired |=> tripped_q && fault_code_q == FAULT_UNIT_LOSS && fault_out)
    else $error("unit loss did not trip");

  loss_time_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    loss_en && unit_present ##1 (loss_en && !unit_present) |-> !loss_expired)
    else $error("unit loss fired too early");

  loss_cont_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !trip_sel |-> !loss_expired)
    else $error("unit loss raised under continue policy");

  loss_unseen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !unit_seen_q |-> !loss_expired)
    else $error("unit loss without prior connection");

  loss_rs485_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rs485_via_unit |-> !loss_expired)
    else $error("unit loss raised during RS-485 use");

  jog_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    unit_prev_q && !unit_present && jog_from_unit && !trip_sel |=> decel_stop_q)
    else $error("unit jog not stopped on loss");

  ps_any_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ps_valid && key_any && !in_oper && ps_st_q == PS_IDLE |=> panel_stop_q && decel_stop_q)
    else $error("stop key ignored outside operator mode");

  ps_nofault_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ps_enter && !tripped_q && !fault_in && !loss_expired |=> panel_stop_q && !fault_out)
    else $error("panel stop raised fault output");

  ps_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    panel_stop_q && !ext_rise && !ps_clear && ps_valid |=> panel_stop_q && !restart_ok)
    else $error("panel stop left without clear");

  ps_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    panel_stop_q && ext_rise |=> !panel_stop_q)
    else $error("reset input did not clear panel stop");

  ps_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ps_valid |=> !panel_stop_q)
    else $error("panel stop under low policy");

  low_ext_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !ps_valid && !in_oper && !jog_stop |=> !decel_stop_q)
    else $error("stop key acted outside operator mode");

  ps_coast_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    panel_stop_q && ps_st_d == PS_HELD |=> !coast_sel_q)
    else $error("coast kept during panel stop");

  ps_source_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ps_valid && in_oper && stop_key_panel && !src_panel && ps_st_q == PS_IDLE |=> panel_stop_q)
    else $error("non-source key did not give panel stop");

  ps_rs485_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ps_valid && in_oper && rs485_via_unit && stop_key_panel && ps_st_q == PS_IDLE
    |=> panel_stop_q ##0 decel_stop_q)
    else $error("panel key under RS-485 not a panel stop");

  own_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_oper && key_own && ps_st_q == PS_IDLE |=> !panel_stop_q && decel_stop_q)
    else $error("source key made a panel stop");

endmodule : rsp_policy_ctrl

`default_nettype wire

// [sim/rsp_unit_model.sv]
// Behavioural operator unit, built-in panel keys and start inputs
`timescale 1ns/100ps
`default_nettype none

module rsp_unit_model (
  input  wire logic core_clk,
  output var logic  unit_present,
  output var logic  stop_key_panel,
  output var logic  stop_key_unit,
  output var logic  mode_key_panel,
  output var logic  mode_key_unit,
  output var logic  start_fwd,
  output var logic  start_rev,
  output var logic  motor_stopped
);
  // Unit starts absent so that a power-up without it is exercised first
  initial begin
    {unit_present, stop_key_panel, stop_key_unit, mode_key_panel, mode_key_unit} = 5'h00;
    {start_fwd, start_rev, motor_stopped} = 3'h1;
  end

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic plug(input logic p);
    unit_present = p;
  endtask : plug

  task automatic run(input logic rev);
    motor_stopped = 1'b0;
    start_fwd     = ~rev;
    start_rev     = rev;
  endtask : run

  // Keys are one-cycle pulses; md selects the mode key, u the detachable unit
  task automatic press(input logic u, input logic md);
    {mode_key_unit, mode_key_panel, stop_key_unit, stop_key_panel} = 4'h1 << {md, u};
    step();
    {mode_key_unit, mode_key_panel, stop_key_unit, stop_key_panel} = 4'h0;
  endtask : press

  // Standstill and released starts; the mode key press follows separately
  task automatic finish;
    step();
    motor_stopped = 1'b1;
    start_fwd     = 1'b0;
    start_rev     = 1'b0;
  endtask : finish
endmodule : rsp_unit_model
`default_nettype wire

// [sim/reset_accept_and_panel_stop_policy_test.sv]
// Self-checking bench for the reset, unit-loss and panel-stop policy controller
`timescale 1ns/100ps
`default_nettype none

module reset_accept_and_panel_stop_policy_test;
  import rsp_pkg::*;
  // Short loss interval keeps the run brief
  localparam int unsigned LOSS = 16;
  logic       core_clk, sys_rst, policy_wr, ext_reset_in, comm_reset_req, unit_reset_key, fault_in;
  logic [4:0] policy_wdata, policy_q, exp_pol, p;
  logic [7:0] fault_in_code, fault_code_q, code;
  logic [1:0] op_mode, e;
  logic       rs485_via_unit, cmd_src_unit, jog_from_unit, stop_method_coast, u;
  logic       unit_present, stop_key_panel, stop_key_unit, mode_key_panel, mode_key_unit;
  logic       start_fwd, start_rev, motor_stopped, policy_bad_q, tripped_q, fault_out;
  logic       reset_exec_q, drive_off_q, accum_clr_q, decel_stop_q, coast_sel_q;
  logic       panel_stop_q, ps_from_unit_q, restart_ok;
  int         bad_count, n_tests, k;

  rsp_policy_ctrl #(.LOSS_CYCLES(LOSS)) i_dut (
    .core_clk, .sys_rst, .policy_wr, .policy_wdata, .policy_q, .policy_bad_q, .ext_reset_in,
    .comm_reset_req, .unit_reset_key, .fault_in, .fault_in_code, .unit_present, .rs485_via_unit,
    .cmd_src_unit, .jog_from_unit, .op_mode, .stop_key_panel, .stop_key_unit, .mode_key_panel,
    .mode_key_unit, .start_fwd, .start_rev, .motor_stopped, .stop_method_coast, .tripped_q,
    .fault_out, .fault_code_q, .reset_exec_q, .drive_off_q, .accum_clr_q, .decel_stop_q,
    .coast_sel_q, .panel_stop_q, .ps_from_unit_q, .restart_ok);

  rsp_unit_model i_unit (
    .core_clk, .unit_present, .stop_key_panel, .stop_key_unit, .mode_key_panel, .mode_key_unit,
    .start_fwd, .start_rev, .motor_stopped);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic legal(input logic [4:0] v);
    return (v <= POLICY_MAX_LO) || (v >= POLICY_MIN_HI && v <= POLICY_MAX_HI);
  endfunction : legal

  // Even settings take a reset at any time, odd ones only when tripped
  function automatic logic accept(input logic [4:0] v, input logic trip);
    return trip || !v[0];
  endfunction : accept

  // Returns {panel stop, decelerate}
  function automatic logic [1:0] stop_exp(input logic [4:0] v, input logic [1:0] m, input logic key_u,
                                          input logic src, input logic rs);
    if (v < POLICY_MIN_HI) return {1'b0, m == MODE_OPER};
    if (m != MODE_OPER) return 2'b11;
    return {rs || (key_u != src), 1'b1};
  endfunction : stop_exp

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic wr(input logic [4:0] v);
    policy_wr    = 1'b1;
    policy_wdata = v;
    step();
    policy_wr    = 1'b0;
    if (legal(v)) exp_pol = v;
  endtask : wr

  // kind 0 communication request, 1 reset input, 2 unit reset key; answer is checked
  task automatic req(input int kind, input logic exp);
    {unit_reset_key, ext_reset_in, comm_reset_req} = 3'h1 << kind;
    step();
    {unit_reset_key, ext_reset_in, comm_reset_req} = 3'h0;
    chk(reset_exec_q, exp, "reset pulse");
    chk(drive_off_q, exp, "drive off");
    chk(accum_clr_q, exp, "accum clear");
    step();
  endtask : req

  task automatic trip(input logic [7:0] c);
    fault_in      = 1'b1;
    fault_in_code = c;
    step();
    fault_in      = 1'b0;
    chk(tripped_q, 1'b1, "trip");
    chk(fault_code_q, c, "fault code");
  endtask : trip

  initial begin
    {policy_wr, ext_reset_in, comm_reset_req, unit_reset_key, fault_in} = 5'h00;
    {rs485_via_unit, cmd_src_unit, jog_from_unit, stop_method_coast} = 4'h1;
    policy_wdata  = 5'h00;
    fault_in_code = 8'h00;
    op_mode       = MODE_OPER;
    exp_pol       = POLICY_INIT;
    bad_count     = 0;
    n_tests       = 0;
    sys_rst       = 1'b1;
    void'($urandom(32'hA2E061D8));
    repeat (5) step();
    sys_rst = 1'b0;
    rs485_via_unit = 1'b0;
    chk(policy_q, 5'h0E, "initial setting");
    chk(restart_ok, 1'b1, "restart after reset");
    // Unit absent since power-up never counts as a loss
    wr(5'h10);
    repeat (LOSS + 4) step();
    chk(tripped_q, 1'b0, "absent at power-up");
    i_unit.plug(1'b1);
    step();
    i_unit.plug(1'b0);
    repeat (LOSS) step();
    chk(tripped_q, 1'b0, "loss too early");
    k = 0;
    while (tripped_q !== 1'b1 && k < 6) begin
      step();
      k++;
    end
    if (k == 6) begin
      chk(tripped_q, 1'b1, "loss trip timeout");
      print_verdict();
    end
    chk(8'(k), 8'h01, "loss trip cycle");
    chk(fault_code_q, FAULT_UNIT_LOSS, "loss code");
    chk(fault_out, 1'b1, "fault output");
    i_unit.plug(1'b1);
    req(0, 1'b1);
    chk(tripped_q, 1'b0, "trip cleared");
    // Detection off with the link on the unit connector
    rs485_via_unit = 1'b1;
    i_unit.plug(1'b0);
    repeat (LOSS + 4) step();
    chk(tripped_q, 1'b0, "link disables loss");
    i_unit.plug(1'b1);
    step();
    rs485_via_unit = 1'b0;
    // Continue policy: unit jog decelerates, no trip
    wr(5'h0E);
    jog_from_unit = 1'b1;
    step();
    i_unit.plug(1'b0);
    step();
    chk(decel_stop_q, 1'b1, "jog decel on loss");
    repeat (LOSS + 4) step();
    chk(tripped_q, 1'b0, "continue on loss");
    jog_from_unit = 1'b0;
    i_unit.plug(1'b1);
    // Every write value while running; illegal ones refused
    i_unit.run(1'b0);
    for (int v = 0; v < 32; v++) begin
      wr(v[4:0]);
      chk(policy_q, exp_pol, "setting");
      chk(policy_bad_q, !legal(v[4:0]), "illegal flag");
      // Idle cycle between writes so the illegal flag can be seen to drop after one cycle
      step();
      chk(policy_bad_q, 1'b0, "illegal flag one cycle");
    end
    // Reset acceptance for each legal setting, untripped then tripped
    for (int i = 0; i < 8; i++) begin
      p = (i < 4) ? 5'(i) : 5'(i + 10);
      wr(p);
      req($urandom % 2, accept(p, 1'b0));
      req(2, 1'b0);
      code = 8'(1 + $urandom % 254);
      trip(code);
      req($urandom % 2, accept(p, 1'b1));
      chk(tripped_q, 1'b0, "tripped cleared");
      trip(code);
      req(2, 1'b1);
    end
    // Random stop-key cases over setting, mode, key source and link
    for (int i = 0; i < 40; i++) begin
      k = $urandom % 8;
      p = (k < 4) ? 5'(k) : 5'(k + 10);
      wr(p);
      op_mode           = 2'($urandom % 3);
      cmd_src_unit      = 1'($urandom);
      rs485_via_unit    = 1'($urandom);
      stop_method_coast = 1'($urandom);
      u                 = 1'($urandom);
      i_unit.run(1'($urandom));
      step();
      i_unit.press(u, 1'b0);
      e = stop_exp(p, op_mode, u, cmd_src_unit, rs485_via_unit);
      chk(panel_stop_q, e[1], "panel stop");
      chk(decel_stop_q, e[0], "decel");
      chk(fault_out, 1'b0, "no fault on stop");
      chk(restart_ok, !e[1], "restart blocked");
      chk(coast_sel_q, stop_method_coast && !e[1], "coast select");
      // Standstill and released starts first, so only the key source decides
      i_unit.finish();
      if (e[1]) begin
        chk(ps_from_unit_q, u, "issuing unit");
        i_unit.press(~u, 1'b1);
        chk(panel_stop_q, 1'b1, "other unit clear");
        step();
      end
      i_unit.press(u, 1'b1);
      chk(panel_stop_q, 1'b0, "clear by issuer");
      chk(restart_ok, 1'b1, "restart allowed");
    end
    // Reset input and power cycle both leave panel stop
    wr(5'h0F);
    op_mode = MODE_EXT;
    i_unit.run(1'b0);
    i_unit.press(1'b1, 1'b0);
    chk(panel_stop_q, 1'b1, "panel stop ext");
    ext_reset_in = 1'b1;
    step();
    chk(panel_stop_q, 1'b0, "reset input clears");
    chk(reset_exec_q, 1'b0, "refused untripped");
    trip(8'h33);
    step();
    chk(tripped_q, 1'b1, "held input counts once");
    chk(reset_exec_q, 1'b0, "held input no pulse");
    ext_reset_in = 1'b0;
    step();
    req(1, 1'b1);
    i_unit.press(1'b0, 1'b0);
    chk(panel_stop_q, 1'b1, "panel stop before power cycle");
    sys_rst = 1'b1;
    step();
    sys_rst = 1'b0;
    chk(panel_stop_q, 1'b0, "power cycle clears");
    chk(policy_q, 5'h0E, "setting restored");
    print_verdict();
  end
endmodule : reset_accept_and_panel_stop_policy_test
`default_nettype wire
